/* src/vic_pkg.sv */
// Purpose: Shared constants for the vectored interrupt controller.
// Assumes: Register indices are local to the controller's plain register port.
// Notes: Vectors are program memory word addresses.
package vic_pkg;
	localparam int unsigned VIC_ADDR_W = 1;
	localparam logic [0:0] VIC_REG_CTRL_A = 1'h0;
	localparam logic [0:0] VIC_REG_CTRL_B = 1'h1;
	localparam int unsigned VIC_SRC_N = 6;
	localparam int unsigned VIC_VEC_W = 8;
	// Bit positions in irq_ctrl_a.
	localparam int unsigned VIC_A_GIE = 0;
	localparam int unsigned VIC_A_EN_LO = 1;
	localparam int unsigned VIC_A_FLAG_LO = 4;
	localparam int unsigned VIC_A_TEST = 7;
	// Bit positions in irq_ctrl_b.
	localparam int unsigned VIC_B_EN_LO = 0;
	localparam int unsigned VIC_B_FLAG_LO = 4;
	localparam int unsigned VIC_B_ADC_FLAG = 5;
	localparam logic [7:0] VIC_CTRL_B_IMPL = 8'h77;
	localparam logic [7:0] VIC_CTRL_A_IMPL = 8'h7f;
	localparam logic [7:0] VIC_CTRL_RESET = 8'h00;
	// Source order, index 0 is the highest priority.
	localparam int unsigned VIC_SRC_EXT = 0;
	localparam int unsigned VIC_SRC_T0 = 1;
	localparam int unsigned VIC_SRC_T1 = 2;
	localparam int unsigned VIC_SRC_MULTI = 3;
	localparam int unsigned VIC_SRC_ADC = 4;
	localparam int unsigned VIC_SRC_TOUCH = 5;
	localparam logic [7:0] VIC_VEC_EXT = 8'h04;
	localparam logic [7:0] VIC_VEC_T0 = 8'h08;
	localparam logic [7:0] VIC_VEC_T1 = 8'h0c;
	localparam logic [7:0] VIC_VEC_MULTI = 8'h10;
	localparam logic [7:0] VIC_VEC_ADC = 8'h14;
	localparam logic [7:0] VIC_VEC_TOUCH = 8'h18;
	localparam logic [1:0] VIC_EDGE_FALL = 2'h0;
	localparam logic [1:0] VIC_EDGE_RISE = 2'h1;
	localparam logic [1:0] VIC_EDGE_BOTH = 2'h2;
endpackage

/* src/vic_edge_detect.sv */
// Purpose: Synchronise the external interrupt pin and report a selected edge.
// Assumes: The pin is asynchronous to mclk.
// Notes: Reserved edge code 3 detects nothing.
module vic_edge_detect
	import vic_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic pin_in,
	input wire logic [1:0] edge_sel,
	output logic edge_pulse
);
	typedef struct packed {
		logic meta;
		logic sync;
		logic prev;
		logic [1:0] settle;
	} vic_edge_state_type;

	vic_edge_state_type state_ff;
	vic_edge_state_type nxt_state;

	always_comb begin
		nxt_state = state_ff;
		nxt_state.meta = pin_in;
		nxt_state.sync = state_ff.meta;
		nxt_state.prev = state_ff.sync;
		if (state_ff.settle != 2'h3) begin
			nxt_state.settle = state_ff.settle + 2'h1;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_comb begin
		unique case (edge_sel)
			VIC_EDGE_FALL: edge_pulse = state_ff.prev & ~state_ff.sync;
			VIC_EDGE_RISE: edge_pulse = ~state_ff.prev & state_ff.sync;
			VIC_EDGE_BOTH: edge_pulse = state_ff.prev ^ state_ff.sync;
			default: edge_pulse = 1'b0;
		endcase
		// Hides the false edge that the zero reset value would show against a high pin.
		if (state_ff.settle != 2'h3) begin
			edge_pulse = 1'b0;
		end
	end
endmodule

/* src/vic_top.sv */
// Function
// - Multi flag self-clears, origin flags stay set; the code keeps no origin flags, and the multi flag clears on service or write
// - ADC done signal sets adc_done_flag bit5
// - ADC request branches to 14H, clears flags
// - Nesting held until isr_exit_with_enable or re-enable
// - Isr_exit_with_enable sets global enable, ret does not
// - Requests serviced at next phase-two pulse
// - Fixed priority order, global enable masks all
// - Flags stay set until serviced or cleared
// - Ctrl A bits 0-3 are enables
// - Ctrl A bits 4-6 are request flags
// - Ctrl B bits 0-2 enables, 3,7 zero
// - Ctrl B bits 4-6 are request flags
// - Touch completion sets flag, vector 18H
// - Wake on interrupt, port, watchdog, timer
// - No acknowledge while the stack is full
// - External pin edge sets flag, vector 04H
// - Timer one like timer zero, vector 0CH
// - Any multi source request sets multi flag
//
// Purpose: Six-source vectored interrupt controller for an 8-bit core.
// Assumes: Core gives a phase_two_pulse strobe, stack full level and return strobes.
// Notes: Registers reached over a plain port with read data one cycle later.
//
// The register offsets and the strobed register port were left to the implementer.
module vic_top
	import vic_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [vic_pkg::VIC_ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic ext_irq_pin,
	input wire logic [1:0] ext_edge_sel,
	input wire logic timer0_overflow,
	input wire logic timer1_overflow,
	input wire logic [2:0] multi_src_req,
	input wire logic adc_conv_done,
	input wire logic touch_done,
	input wire logic phase_two_pulse,
	input wire logic stack_full,
	input wire logic isr_exit_with_enable,
	input wire logic plain_subroutine_exit,
	input wire logic porta_wake_event,
	input wire logic wdt_overflow,
	input wire logic timer_wake_event,
	output logic irq_ack,
	output logic [vic_pkg::VIC_VEC_W-1:0] irq_vector,
	output logic push_pc,
	output logic wake_req,
	output logic test_mode
);
	// ************************************************************
	// State
	// ************************************************************
	// One register holds all state except the edge detector's synchroniser, so reset and update sit in one place.
	typedef struct packed {
		logic gie;
		logic [VIC_SRC_N-1:0] enable;
		logic [VIC_SRC_N-1:0] flag;
		logic test_bit;
		logic ack;
		logic [VIC_VEC_W-1:0] vector;
		logic wake;
		logic [7:0] rdata;
	} vic_state_type;

	vic_state_type state_ff;
	vic_state_type nxt_state;
	logic ext_edge;
	logic [VIC_SRC_N-1:0] src_event;
	logic [VIC_SRC_N-1:0] pending;
	logic [VIC_SRC_N-1:0] grant;
	logic [VIC_SRC_N-1:0] svc_clear;
	logic [VIC_SRC_N-1:0] sw_clear;
	logic wr_a;
	logic wr_b;
	logic rd_a;
	logic rd_b;
	logic [VIC_SRC_N-1:0] flag_keep;
	logic [VIC_SRC_N-1:0] nxt_flag;
	logic [7:0] image_a;
	logic [7:0] image_b;
	logic wake_any;
	logic gie_set;
	logic gie_clear;
	logic ack_now;
	logic [VIC_VEC_W-1:0] vec_now;

	// Returns the one-hot of the lowest set bit, the highest priority.
	function automatic logic [VIC_SRC_N-1:0] vic_pick(input logic [VIC_SRC_N-1:0] req);
		logic [VIC_SRC_N-1:0] one;
		one = '0;
		// Scans from the lowest priority up, so the last hit wins.
		for (int i = VIC_SRC_N - 1; i >= 0; i--) begin
			if (req[i]) begin
				one = '0;
				one[i] = 1'b1;
			end
		end
		return one;
	endfunction

	// Maps a one-hot grant to its branch address; no grant gives zero.
	function automatic logic [VIC_VEC_W-1:0] vic_vec(input logic [VIC_SRC_N-1:0] g);
		logic [VIC_VEC_W-1:0] v;
		v = '0;
		if (g[VIC_SRC_EXT]) v = VIC_VEC_EXT;
		if (g[VIC_SRC_T0]) v = VIC_VEC_T0;
		if (g[VIC_SRC_T1]) v = VIC_VEC_T1;
		if (g[VIC_SRC_MULTI]) v = VIC_VEC_MULTI;
		if (g[VIC_SRC_ADC]) v = VIC_VEC_ADC;
		if (g[VIC_SRC_TOUCH]) v = VIC_VEC_TOUCH;
		return v;
	endfunction

	// Packs irq_ctrl_a: test bit, three flags, three enables, global enable.
	function automatic logic [7:0] vic_image_a(input vic_state_type st);
		logic [7:0] img;
		img = 8'h00;
		img[VIC_A_GIE] = st.gie;
		img[VIC_A_EN_LO +: 3] = st.enable[VIC_SRC_T1:VIC_SRC_EXT];
		img[VIC_A_FLAG_LO +: 3] = st.flag[VIC_SRC_T1:VIC_SRC_EXT];
		img[VIC_A_TEST] = st.test_bit;
		return img;
	endfunction

	// Packs irq_ctrl_b; the unused bits 3 and 7 are forced low by the mask.
	function automatic logic [7:0] vic_image_b(input vic_state_type st);
		logic [7:0] img;
		img = 8'h00;
		img[VIC_B_EN_LO +: 3] = st.enable[VIC_SRC_TOUCH:VIC_SRC_MULTI];
		img[VIC_B_FLAG_LO +: 3] = st.flag[VIC_SRC_TOUCH:VIC_SRC_MULTI];
		return img & VIC_CTRL_B_IMPL;
	endfunction

	// ************************************************************
	// Event sources
	// ************************************************************
	// pin edge detect
	vic_edge_detect u_edge (
		.mclk(mclk),
		.rst_n(rst_n),
		.pin_in(ext_irq_pin),
		.edge_sel(ext_edge_sel),
		.edge_pulse(ext_edge)
	);

	always_comb begin
		src_event = '0;
		src_event[VIC_SRC_EXT] = ext_edge;
		src_event[VIC_SRC_T0] = timer0_overflow;
		src_event[VIC_SRC_T1] = timer1_overflow;
		src_event[VIC_SRC_MULTI] = |multi_src_req;
		src_event[VIC_SRC_ADC] = adc_conv_done;
		src_event[VIC_SRC_TOUCH] = touch_done;
	end

	// ************************************************************
	// Arbitration
	// ************************************************************
	always_comb begin
		pending = state_ff.flag & state_ff.enable & {VIC_SRC_N{state_ff.gie}};
		grant = vic_pick(pending);
		// Outside a strobe, or with a full stack, requests wait in their flags.
		// sample at strobe
		if (!phase_two_pulse || stack_full) begin
			grant = '0;
		end
		svc_clear = grant;
	end

	assign wr_a = reg_wr && (reg_addr == VIC_REG_CTRL_A);
	assign wr_b = reg_wr && (reg_addr == VIC_REG_CTRL_B);

	// Writing 0 to a flag bit clears it; writing 1 leaves it as it is.
	always_comb begin
		sw_clear = '0;
		if (wr_a) begin
			sw_clear[VIC_SRC_T1:VIC_SRC_EXT] = ~reg_wdata[VIC_A_FLAG_LO +: 3];
		end
		if (wr_b) begin
			sw_clear[VIC_SRC_TOUCH:VIC_SRC_MULTI] = ~reg_wdata[VIC_B_FLAG_LO +: 3];
		end
	end

	// ************************************************************
	// Next state
	// ************************************************************
	// global enable control
	always_comb begin
		// A plain subroutine exit is not decoded, so it leaves the enable alone.
		gie_set = isr_exit_with_enable;
		gie_clear = |grant;
	end

	always_comb begin
		flag_keep = ~sw_clear & ~svc_clear;
		// A source event in the same cycle as a clear wins, so no request is lost.
		nxt_flag = (state_ff.flag & flag_keep) | src_event;
	end

	always_comb begin
		ack_now = |grant;
		vec_now = state_ff.vector;
		if (ack_now) begin
			vec_now = vic_vec(grant);
		end
	end

	always_comb begin
		nxt_state = state_ff;
		if (wr_a) begin
			nxt_state.gie = reg_wdata[VIC_A_GIE];
			nxt_state.enable[VIC_SRC_T1:VIC_SRC_EXT] = reg_wdata[VIC_A_EN_LO +: 3];
			nxt_state.test_bit = reg_wdata[VIC_A_TEST];
		end
		if (wr_b) begin
			nxt_state.enable[VIC_SRC_TOUCH:VIC_SRC_MULTI] = reg_wdata[VIC_B_EN_LO +: 3];
		end
		if (gie_set) begin
			nxt_state.gie = 1'b1;
		end
		if (gie_clear) begin
			nxt_state.gie = 1'b0;
		end
		nxt_state.flag = nxt_flag;
		nxt_state.ack = ack_now;
		nxt_state.vector = vec_now;
		nxt_state.wake = wake_any;
		nxt_state.rdata = 8'h00;
		if (rd_a) begin
			nxt_state.rdata = image_a;
		end
		if (rd_b) begin
			nxt_state.rdata = image_b;
		end
	end

	// ************************************************************
	// Register port
	// ************************************************************
	assign rd_a = reg_rd && (reg_addr == VIC_REG_CTRL_A);
	assign rd_b = reg_rd && (reg_addr == VIC_REG_CTRL_B);

	always_comb begin
		image_a = vic_image_a(state_ff);
		image_b = vic_image_b(state_ff);
	end

	// ************************************************************
	// Wake
	// ************************************************************
	// any wake source
	always_comb begin
		// The global enable is ignored so that a masked core still wakes.
		wake_any = |(state_ff.flag & state_ff.enable);
		wake_any = wake_any | (|src_event);
		wake_any = wake_any | porta_wake_event | wdt_overflow | timer_wake_event;
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	// Plain subroutine exit leaves the global enable untouched by design.
	assign irq_ack = state_ff.ack;
	// The acknowledge doubles as the push request; only the program counter is saved.
	assign push_pc = state_ff.ack;
	assign irq_vector = state_ff.vector;
	assign wake_req = state_ff.wake;
	assign reg_rdata = state_ff.rdata;
	assign test_mode = state_ff.test_bit;
endmodule

/* tb/vic_monitor.sv */
// Purpose: Port checks for the interrupt controller.
// Assumes: Bound into vic_top.
// Notes: One clock domain.
module vic_monitor
	import vic_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [vic_pkg::VIC_ADDR_W-1:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic phase_two_pulse,
	input wire logic stack_full,
	input wire logic wdt_overflow,
	input wire logic irq_ack,
	input wire logic [vic_pkg::VIC_VEC_W-1:0] irq_vector,
	input wire logic push_pc,
	input wire logic wake_req
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	sequence s_blocked;
		!phase_two_pulse || stack_full;
	endsequence
	sequence s_gap;
		!irq_ack ##1 !irq_ack;
	endsequence
	property p_no_cause; s_blocked |=> !irq_ack; endproperty
	a_no_cause: assert property (p_no_cause) else $error("ack without strobe");
	property p_hold_off; irq_ack |=> s_gap; endproperty
	a_hold_off: assert property (p_hold_off) else $error("ack repeated");
	property p_push; push_pc == irq_ack; endproperty
	a_push: assert property (p_push) else $error("push differs from ack");
	property p_vec_set; irq_ack |-> irq_vector[1:0] == 2'h0 && irq_vector inside {[8'h04:8'h18]};
	endproperty
	a_vec_set: assert property (p_vec_set) else $error("bad vector");
	property p_vec_hold; !irq_ack |-> $stable(irq_vector); endproperty
	a_vec_hold: assert property (p_vec_hold) else $error("vector moved");
	property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
	property p_b_unused; $past(reg_rd && reg_addr == VIC_REG_CTRL_B) |-> !reg_rdata[3] && !reg_rdata[7];
	endproperty
	a_b_unused: assert property (p_b_unused) else $error("unused bit set");
	property p_wake; $past(wdt_overflow) |-> wake_req; endproperty
	a_wake: assert property (p_wake) else $error("no wake");
endmodule
bind vic_top vic_monitor mon_u (.*);

/* tb/vic_core_model.sv */
// Purpose: Core stand-in making phase-two strobes and tracking stack depth.
// Assumes: One strobe every fourth clock.
// Notes: fill forces a full stack; each return pops one level.
module vic_core_model #(
	parameter int STACK_LEVELS = 8
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic push_pc,
	input wire logic fill,
	input wire logic ret_pulse,
	output logic phase_two_pulse,
	output logic stack_full
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] depth_ff;
	logic [1:0] ph_ff;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			depth_ff <= 4'h0;
			ph_ff <= 2'h0;
		end else begin
			ph_ff <= ph_ff + 2'h1;
			depth_ff <= fill ? 4'(STACK_LEVELS) :
				depth_ff + 4'(push_pc) - 4'(ret_pulse && depth_ff != 4'h0);
		end
	end
	assign phase_two_pulse = ph_ff == 2'h3;
	assign stack_full = depth_ff == 4'(STACK_LEVELS);
endmodule

/* tb/tb_top.sv */
// Purpose: Self-checking bench for the interrupt controller.
// Assumes: Core model strobes phase two every fourth clock.
// Notes: Seeded random edge choice and multi source bit.
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import vic_pkg::*;
	logic mclk, rst_n, wr_s, rd_s, pin, fill, ack, push, p2, full, wake, tmode;
	logic [VIC_ADDR_W-1:0] addr;
	logic [7:0] wd, rdat, vec;
	logic [5:0] ev;
	logic [2:0] msel, wk;
	logic [1:0] sel, ex;
	int bad_count, total_checks, s;
	always #4 mclk = ~mclk;
	vic_core_model core_u (.mclk(mclk), .rst_n(rst_n), .push_pc(push), .fill(fill),
		.ret_pulse(|ex), .phase_two_pulse(p2), .stack_full(full));
	vic_top dut_u (.mclk(mclk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr_s),
		.reg_rd(rd_s), .reg_rdata(rdat), .ext_irq_pin(pin), .ext_edge_sel(sel),
		.timer0_overflow(ev[1]), .timer1_overflow(ev[2]), .multi_src_req(ev[3] ? msel : 3'h0),
		.adc_conv_done(ev[4]), .touch_done(ev[5]), .phase_two_pulse(p2), .stack_full(full),
		.isr_exit_with_enable(ex[1]), .plain_subroutine_exit(ex[0]), .porta_wake_event(wk[0]),
		.wdt_overflow(wk[1]), .timer_wake_event(wk[2]), .irq_ack(ack), .irq_vector(vec),
		.push_pc(push), .wake_req(wake), .test_mode(tmode));
	function automatic logic [7:0] bit_of(int i, bit f);
		return 8'h01 << (i < 3 ? i + 1 + 3 * f : i - 3 + 4 * f);
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [VIC_ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge mclk);
		{wr_s, addr, wd} <= {1'b1, a, d};
		@(posedge mclk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [VIC_ADDR_W-1:0] a, input logic [7:0] e);
		@(posedge mclk);
		{rd_s, addr} <= {1'b1, a};
		@(posedge mclk);
		rd_s <= 1'b0;
		@(negedge mclk);
		chk(rdat, e);
	endtask
	task automatic pulse(input logic [1:0] x, input logic f);
		@(posedge mclk);
		{ex, fill} <= {x, f};
		@(posedge mclk);
		{ex, fill} <= 3'h0;
	endtask
	task automatic fire(input int i);
		@(posedge mclk);
		if (i == 0) pin <= !pin;
		ev[i] <= 1'b1;
		msel <= 3'(1 << $urandom_range(2));
		@(posedge mclk);
		ev <= 6'h00;
		repeat (4) @(posedge mclk);
	endtask
	task automatic quiet(input int n);
		int c;
		c = 0;
		repeat (n) begin
			@(negedge mclk);
			c += (ack === 1'b1);
		end
		chk(8'(c), 8'h00);
	endtask
	task automatic wait_ack(input logic [7:0] exp);
		int n;
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (ack !== 1'b1 && n < 60);
		if (n >= 60) begin
			bad_count++;
			tally_and_finish();
		end else begin
			chk(vec, exp);
		end
	endtask
	initial begin
		{mclk, rst_n, wr_s, rd_s, pin, fill, addr, wd, ev, msel, wk, sel, ex} = '0;
		bad_count = 0;
		total_checks = 0;
		void'($urandom(73313));
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		rd(0, 8'h00);
		rd(1, 8'h00);
		wr(1, 8'hff);
		rd(1, 8'h07);
		wr(0, 8'h0f);
		rd(0, 8'h0f);
		for (int j = 0; j < 3; j++) begin
			@(posedge mclk);
			wk <= 3'(1 << j);
			@(posedge mclk);
			wk <= 3'h0;
			@(negedge mclk);
			chk(8'(wake), 8'h01);
			@(negedge mclk);
			chk(8'(wake), 8'h00);
		end
		@(posedge mclk);
		{sel, pin} <= {2'h3, 1'b1};
		repeat (6) @(posedge mclk);
		rd(0, 8'h0f);
		$display("registers done");
		for (int i = 0; i < 6; i++) begin
			wr(0, 8'h00);
			s = $urandom_range(2);
			@(posedge mclk);
			{sel, pin} <= {2'(s), s == 0};
			repeat (4) @(posedge mclk);
			wr(0, 8'h00);
			wr(1, 8'h00);
			fire(i);
			rd(i > 2, bit_of(i, 1));
			wr(1, i > 2 ? bit_of(i, 0) | 8'h70 : 8'h70);
			wr(0, i > 2 ? 8'h71 : bit_of(i, 0) | 8'h71);
			wait_ack(8'h04 + 8'(4 * i));
			rd(i > 2, bit_of(i, 0));
			pulse(2'h2, 1'b0);
		end
		pulse(2'h0, 1'b1);
		fire(4);
		wr(1, 8'h72);
		wr(0, 8'h71);
		quiet(16);
		pulse(2'h1, 1'b0);
		wait_ack(VIC_VEC_ADC);
		pulse(2'h2, 1'b0);
		$display("sources done");
		sel <= VIC_EDGE_BOTH;
		wr(0, 8'h00);
		wr(1, 8'h77);
		wr(0, 8'h0e);
		for (int i = 0; i < 6; i++) fire(i);
		wr(0, 8'h7f);
		@(negedge mclk);
		chk(8'(tmode), 8'h00);
		for (int k = 0; k < 6; k++) begin
			wait_ack(8'h04 + 8'(4 * k));
			if (k == 0) begin
				pulse(2'h1, 1'b0);
				quiet(12);
			end
			pulse(2'h2, 1'b0);
		end
		$display("priority done");
		tally_and_finish();
	end
endmodule
